// ==== rtl/tmss_map.svh ====
// constants for the mode-select and start-up block: bus offsets, reset values, counts
// assumes inclusion by rtl/tmss_top.sv and the dv sources, before their modules
`ifndef TMSS_MAP_SVH
`define TMSS_MAP_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define TMSS_A_CTRL      8'h00
`define TMSS_A_FDRIVE    8'h04
`define TMSS_A_DUTY      8'h08
`define TMSS_A_DUTYMAX   8'h0c
`define TMSS_A_STATUS    8'h10
`define TMSS_A_NOTIFY    8'h14

// -----------------------------------------------------------------
// control and notify bits
// -----------------------------------------------------------------
`define TMSS_CTRL_START  0
`define TMSS_CTRL_STOP   1
`define TMSS_NOT_PKT     0
`define TMSS_NOT_ABN     1

// -----------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------
`define TMSS_PLL_MHZ     128
`define TMSS_REF_MHZ     8
`define TMSS_TICK_INC    12'h010
`define TMSS_FDRV_DEF    11'h400
`define TMSS_DUTYMAX_DEF 10'h1c0
`define TMSS_SA_SHIFT    6
`define TMSS_SETUP_CYC   4'h8
`define TMSS_OSC_DIV     4'hb
`define TMSS_TXT_DEF     32'd100000000
`define TMSS_SADDR_LO    7'h2a
`define TMSS_SADDR_HI    7'h2b

`endif

// ==== rtl/tmss_pkg.sv ====
// types for the mode-select and start-up block
// assumes nothing beyond a SystemVerilog compiler
package tmss_pkg;

	// -----------------------------------------------------------------
	// top-level states and drive sub-modes
	// -----------------------------------------------------------------
	typedef enum logic {
		TMSS_ST_SETUP,
		TMSS_ST_DRIVE
	} tmss_state_t;

	typedef enum logic [2:0] {
		TMSS_M_STANDALONE,
		TMSS_M_APC_EEPROM,
		TMSS_M_APC_MCU,
		TMSS_M_MCU,
		TMSS_M_INVALID
	} tmss_mode_t;

endpackage : tmss_pkg

// ==== rtl/tmss_top.sv ====
// mode selection, start-up sequencing and bridge pulse timing of the transmitter
// assumes CORE_CLK at 100 MHz, pins asynchronous to it, packet logic on CORE_CLK
`timescale 1ns/1ps
`default_nettype none
`include "tmss_map.svh"

// Behaviour
// - only setup and power-drive top states
// - setup applies settings from strap levels
// - both straps low, width strap high: standalone
// - role and auto straps high: eeprom power control
// - auto mode regulates duty from packets
// - role low, auto high: mcu writes settings
// - all straps low: mcu-controlled mode
// - standby low holds block in reset
// - notify output on packet or abnormal
// - period 1024 of 128 MHz gives 125 kHz
// - topology strap chooses gate drive behaviour
// - clock strap picks oscillator or reference input
// - address strap sets serial target address
// - role strap sets serial controller or target
// - calibration enabled only with strap high
// - topology low full bridge, high half
// - timer stops drive after fixed period
module tmss_top import tmss_pkg::*; #(
	parameter int unsigned TX_TIMER_CYCLES = `TMSS_TXT_DEF
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RSTN,
	input  wire logic        STANDBY_RESET_IN,
	input  wire logic        REF_CLOCK_IN,
	input  wire logic        BUS_ROLE_STRAP,
	input  wire logic        AUTO_POWER_STRAP,
	input  wire logic        PULSE_WIDTH_STRAP_A,
	input  wire logic        PULSE_WIDTH_STRAP_B,
	input  wire logic        PULSE_WIDTH_STRAP_C,
	input  wire logic        BRIDGE_TOPOLOGY_STRAP,
	input  wire logic        CLOCK_SOURCE_STRAP,
	input  wire logic        ADDRESS_STRAP,
	input  wire logic        CALIBRATION_STRAP,
	input  wire logic        FAULT_IN,
	input  wire logic        PKT_VALID,
	input  wire logic [7:0]  PKT_POWER_ERR,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	output logic             GATE1_HIGH,
	output logic             GATE1_LOW,
	output logic             GATE2_HIGH,
	output logic             GATE2_LOW,
	output logic             HOST_NOTIFY,
	output logic      [6:0]  SERIAL_TARGET_ADDR,
	output logic             SERIAL_IS_CONTROLLER,
	output logic             CAL_ENABLE,
	output logic             REF_FROM_PIN,
	output logic             DRIVE_ACTIVE
);

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	localparam int NPIN = 12;
	localparam int P_STANDBY_RESET_IN = 11;
	localparam int P_REF = 10;
	localparam int P_FLT = 9;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s1_r;
	logic [NPIN-1:0] pin_s2_r;
	logic [NPIN-1:0] pin_s3_r;
	logic [NPIN-1:0] pin_r;

	assign pin_raw = {STANDBY_RESET_IN, REF_CLOCK_IN, FAULT_IN, CALIBRATION_STRAP,
		ADDRESS_STRAP, CLOCK_SOURCE_STRAP, BRIDGE_TOPOLOGY_STRAP, PULSE_WIDTH_STRAP_C,
		PULSE_WIDTH_STRAP_B, PULSE_WIDTH_STRAP_A, AUTO_POWER_STRAP, BUS_ROLE_STRAP};

	// stage one feeds stage two only; a level counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge CORE_CLK or negedge RSTN) begin
				if (!RSTN) begin
					pin_s1_r[gi] <= 1'b0;
					pin_s2_r[gi] <= 1'b0;
					pin_s3_r[gi] <= 1'b0;
					pin_r[gi]    <= 1'b0;
				end else begin
					pin_s1_r[gi] <= pin_raw[gi];
					pin_s2_r[gi] <= pin_s1_r[gi];
					pin_s3_r[gi] <= pin_s2_r[gi];
					if (pin_s2_r[gi] == pin_s3_r[gi]) begin
						pin_r[gi] <= pin_s3_r[gi];
					end
				end
			end
		end
	endgenerate

	logic active;
	assign active = pin_r[P_STANDBY_RESET_IN];

	// -----------------------------------------------------------------
	// state, strap capture and mode decode
	// -----------------------------------------------------------------
	tmss_state_t state_r;
	tmss_mode_t  mode_r;
	tmss_mode_t  mode_nxt;
	logic [3:0]  settle_r;
	logic [8:0]  strap_r;
	logic        run_r;
	logic        stopped_r;
	logic        timeout;

	// straps as seen by the synchronisers: {cal, addr, clk, topo, pw c..a, auto, role}
	logic [8:0] strap_now;
	assign strap_now = pin_r[8:0];

	always_comb begin
		mode_nxt = TMSS_M_INVALID;
		if (strap_now[4:2] != 3'h0) begin
			if (strap_now[1:0] == 2'h0) begin
				mode_nxt = TMSS_M_STANDALONE;
			end
		end else begin
			case (strap_now[1:0])
				2'h3: mode_nxt = TMSS_M_APC_EEPROM;
				2'h2: mode_nxt = TMSS_M_APC_MCU;
				2'h0: mode_nxt = TMSS_M_MCU;
				default: mode_nxt = TMSS_M_INVALID;
			endcase
		end
	end

	// setup waits for the synchronisers to fill, then latches straps once
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r  <= TMSS_ST_SETUP;
			settle_r <= 4'h0;
		end else if (!active) begin
			state_r  <= TMSS_ST_SETUP;
			settle_r <= 4'h0;
		end else begin
			case (state_r)
				TMSS_ST_SETUP: begin
					if (settle_r == `TMSS_SETUP_CYC) begin
						state_r <= TMSS_ST_DRIVE;
					end else begin
						settle_r <= settle_r + 4'h1;
					end
				end
				TMSS_ST_DRIVE: state_r <= TMSS_ST_DRIVE;
				default: state_r <= TMSS_ST_SETUP;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			strap_r <= 9'h000;
			mode_r  <= TMSS_M_INVALID;
		end else if (state_r == TMSS_ST_SETUP && settle_r == `TMSS_SETUP_CYC) begin
			strap_r <= strap_now;
			mode_r  <= mode_nxt;
		end
	end

	logic apc_mode;
	assign apc_mode = (mode_r == TMSS_M_APC_EEPROM) || (mode_r == TMSS_M_APC_MCU);

	assign SERIAL_IS_CONTROLLER = strap_r[0];
	assign SERIAL_TARGET_ADDR   = strap_r[7] ? `TMSS_SADDR_HI : `TMSS_SADDR_LO;
	assign CAL_ENABLE           = strap_r[8];
	assign REF_FROM_PIN         = !strap_r[6];

	// -----------------------------------------------------------------
	// settings registers
	// -----------------------------------------------------------------
	logic [10:0] fdrive_r;
	logic [9:0]  duty_r;
	logic [9:0]  dutymax_r;
	logic        wr_ok;
	logic        entry;

	// standalone ignores settings writes; other modes take them in the drive state only
	assign wr_ok = REG_WR && state_r == TMSS_ST_DRIVE && mode_r != TMSS_M_STANDALONE;
	assign entry = state_r == TMSS_ST_SETUP && settle_r == `TMSS_SETUP_CYC;

	logic signed [11:0] duty_adj;
	assign duty_adj = $signed({2'b00, duty_r}) + 12'(signed'(PKT_POWER_ERR));

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			fdrive_r  <= `TMSS_FDRV_DEF;
			duty_r    <= 10'h000;
			dutymax_r <= `TMSS_DUTYMAX_DEF;
		end else if (!active) begin
			fdrive_r  <= `TMSS_FDRV_DEF;
			duty_r    <= 10'h000;
			dutymax_r <= `TMSS_DUTYMAX_DEF;
		end else if (entry) begin
			fdrive_r <= `TMSS_FDRV_DEF;
			if (mode_nxt == TMSS_M_STANDALONE) begin
				duty_r <= 10'({strap_now[4:2], 6'h00}) ;
			end
		end else if (wr_ok) begin
			case (REG_ADDR)
				`TMSS_A_FDRIVE:  fdrive_r  <= REG_WDATA[10:0];
				`TMSS_A_DUTY:    duty_r    <= REG_WDATA[9:0];
				`TMSS_A_DUTYMAX: dutymax_r <= REG_WDATA[9:0];
				default: ;
			endcase
		end else if (apc_mode && PKT_VALID) begin
			// closed loop: packet error steers duty, clamped to 0..duty max
			if (duty_adj < 0) begin
				duty_r <= 10'h000;
			end else if (duty_adj > $signed({2'b00, dutymax_r})) begin
				duty_r <= dutymax_r;
			end else begin
				duty_r <= duty_adj[9:0];
			end
		end
	end

	// -----------------------------------------------------------------
	// run control and transmitter timer
	// -----------------------------------------------------------------
	logic [31:0] txt_r;
	logic        start_cmd;
	logic        stop_cmd;

	assign start_cmd = wr_ok && REG_ADDR == `TMSS_A_CTRL && REG_WDATA[`TMSS_CTRL_START];
	assign stop_cmd  = wr_ok && REG_ADDR == `TMSS_A_CTRL && REG_WDATA[`TMSS_CTRL_STOP];
	assign timeout   = state_r == TMSS_ST_DRIVE && txt_r >= TX_TIMER_CYCLES;

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			txt_r <= 32'h0;
		end else if (!active || state_r != TMSS_ST_DRIVE) begin
			txt_r <= 32'h0;
		end else if (!timeout) begin
			txt_r <= txt_r + 32'h1;
		end
	end

	// faults and timer expiry latch off until standby or reset
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			stopped_r <= 1'b0;
		end else if (!active) begin
			stopped_r <= 1'b0;
		end else if (timeout || (state_r == TMSS_ST_DRIVE && pin_r[P_FLT])) begin
			stopped_r <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			run_r <= 1'b0;
		end else if (!active || stopped_r || timeout) begin
			run_r <= 1'b0;
		end else if (entry) begin
			run_r <= mode_nxt != TMSS_M_MCU && mode_nxt != TMSS_M_INVALID;
		end else if (mode_r == TMSS_M_MCU) begin
			if (stop_cmd) begin
				run_r <= 1'b0;
			end else if (start_cmd) begin
				run_r <= 1'b1;
			end
		end
	end

	assign DRIVE_ACTIVE = run_r;

	// -----------------------------------------------------------------
	// time base: 8 MHz edges stand for 16 ticks of the 128 MHz pll
	// -----------------------------------------------------------------
	logic       ref_d_r;
	logic [3:0] osc_r;
	logic       tick;

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ref_d_r <= 1'b0;
			osc_r   <= 4'h0;
		end else begin
			ref_d_r <= pin_r[P_REF];
			osc_r   <= (osc_r == `TMSS_OSC_DIV) ? 4'h0 : osc_r + 4'h1;
		end
	end

	// on-chip oscillator is approximated from the core clock, about 8.3 MHz
	assign tick = strap_r[6] ? (osc_r == 4'h0) : (pin_r[P_REF] && !ref_d_r);

	logic [10:0] ph_r;
	logic [11:0] ph_sum;
	assign ph_sum = {1'b0, ph_r} + `TMSS_TICK_INC;

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ph_r <= 11'h000;
		end else if (!run_r) begin
			ph_r <= 11'h000;
		end else if (tick) begin
			if (ph_sum >= {1'b0, fdrive_r}) begin
				ph_r <= 11'(ph_sum - {1'b0, fdrive_r});
			end else begin
				ph_r <= ph_sum[10:0];
			end
		end
	end

	// -----------------------------------------------------------------
	// gate drive: high sides active low, low sides active high
	// -----------------------------------------------------------------
	logic [10:0] half;
	logic        first;
	logic [10:0] ph_in;
	logic        pulse;

	assign half  = {1'b0, fdrive_r[10:1]};
	assign first = ph_r < half;
	assign ph_in = first ? ph_r : 11'(ph_r - half);
	assign pulse = run_r && ph_in < {1'b0, duty_r};

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			GATE1_HIGH <= 1'b1;
			GATE1_LOW  <= 1'b0;
			GATE2_HIGH <= 1'b1;
			GATE2_LOW  <= 1'b0;
		end else if (strap_r[5]) begin
			GATE1_HIGH <= !(pulse && first);
			GATE1_LOW  <= pulse && !first;
			GATE2_HIGH <= 1'b1;
			GATE2_LOW  <= 1'b0;
		end else begin
			GATE1_HIGH <= !(pulse && first);
			GATE1_LOW  <= pulse && !first;
			GATE2_HIGH <= !(pulse && !first);
			GATE2_LOW  <= pulse && first;
		end
	end

	// -----------------------------------------------------------------
	// notification: set wins over a write-one clear
	// -----------------------------------------------------------------
	logic [1:0] notify_r;
	logic [1:0] notify_set;
	logic [1:0] notify_clr;

	assign notify_set = {timeout || (state_r == TMSS_ST_DRIVE && pin_r[P_FLT]),
		PKT_VALID && state_r == TMSS_ST_DRIVE};
	assign notify_clr = (REG_WR && REG_ADDR == `TMSS_A_NOTIFY) ? REG_WDATA[1:0] : 2'h0;

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			notify_r <= 2'h0;
		end else if (!active) begin
			notify_r <= 2'h0;
		end else begin
			notify_r <= (notify_r & ~notify_clr) | notify_set;
		end
	end

	assign HOST_NOTIFY = |notify_r;

	// -----------------------------------------------------------------
	// read port: data in the cycle after the strobe, zero otherwise
	// -----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			REG_RDATA <= 32'h0;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`TMSS_A_CTRL:    REG_RDATA <= {31'h0, run_r};
				`TMSS_A_FDRIVE:  REG_RDATA <= {21'h0, fdrive_r};
				`TMSS_A_DUTY:    REG_RDATA <= {22'h0, duty_r};
				`TMSS_A_DUTYMAX: REG_RDATA <= {22'h0, dutymax_r};
				`TMSS_A_STATUS:  REG_RDATA <= {16'h0, strap_r, mode_r, stopped_r,
					run_r, 1'b0, state_r == TMSS_ST_DRIVE};
				`TMSS_A_NOTIFY:  REG_RDATA <= {30'h0, notify_r};
				default:         REG_RDATA <= 32'h0;
			endcase
		end else begin
			REG_RDATA <= 32'h0;
		end
	end

endmodule : tmss_top
`default_nettype wire

// ==== dv/tmss_checker.sv ====
// port-level checker for the mode-select and start-up block
// assumes one domain on CORE_CLK, RSTN low resets, straps change only in standby
`timescale 1ns/1ps
`default_nettype none
`include "tmss_map.svh"
module tmss_checker #(
	parameter int unsigned TX_TIMER_CYCLES = 200
) (
	input wire logic        CORE_CLK,
	input wire logic        RSTN,
	input wire logic        STANDBY_RESET_IN,
	input wire logic        BUS_ROLE_STRAP,
	input wire logic        BRIDGE_TOPOLOGY_STRAP,
	input wire logic        CLOCK_SOURCE_STRAP,
	input wire logic        ADDRESS_STRAP,
	input wire logic        CALIBRATION_STRAP,
	input wire logic        FAULT_IN,
	input wire logic        PKT_VALID,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic        GATE1_HIGH,
	input wire logic        GATE1_LOW,
	input wire logic        GATE2_HIGH,
	input wire logic        GATE2_LOW,
	input wire logic        HOST_NOTIFY,
	input wire logic [6:0]  SERIAL_TARGET_ADDR,
	input wire logic        SERIAL_IS_CONTROLLER,
	input wire logic        CAL_ENABLE,
	input wire logic        REF_FROM_PIN,
	input wire logic        DRIVE_ACTIVE
);
	// -----------------------------------------------------------------
	// sequences and helper count
	// -----------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	sequence standby_low_s; !STANDBY_RESET_IN [*8]; endsequence
	sequence idle_s; !DRIVE_ACTIVE [*3]; endsequence
	sequence fault_s; FAULT_IN [*4]; endsequence
	// counts unbroken drive; cleared on any drop, so a restart is never blamed
	int unsigned run_cnt_r;
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN)
			run_cnt_r <= 0;
		else if (!DRIVE_ACTIVE)
			run_cnt_r <= 0;
		else if (run_cnt_r < TX_TIMER_CYCLES + 16)
			run_cnt_r <= run_cnt_r + 1;
	end
	standby_off_a: assert property (standby_low_s |-> !DRIVE_ACTIVE && GATE1_HIGH
		&& !GATE1_LOW && !HOST_NOTIFY) else $error("block active in standby");
	idle_gates_a: assert property (idle_s |-> GATE1_HIGH && !GATE1_LOW
		&& GATE2_HIGH && !GATE2_LOW) else $error("gates switch while idle");
	half_bridge_a: assert property (DRIVE_ACTIVE && BRIDGE_TOPOLOGY_STRAP |->
		GATE2_HIGH && !GATE2_LOW) else $error("second leg driven in half bridge");
	full_bridge_a: assert property (DRIVE_ACTIVE && !BRIDGE_TOPOLOGY_STRAP |->
		GATE2_LOW == !GATE1_HIGH && GATE2_HIGH == !GATE1_LOW) else $error("legs not paired");
	addr_strap_a: assert property (DRIVE_ACTIVE |-> SERIAL_TARGET_ADDR ==
		(ADDRESS_STRAP ? `TMSS_SADDR_HI : `TMSS_SADDR_LO)) else $error("target address wrong");
	role_strap_a: assert property (DRIVE_ACTIVE |->
		SERIAL_IS_CONTROLLER == BUS_ROLE_STRAP) else $error("bus role wrong");
	cal_strap_a: assert property (DRIVE_ACTIVE |->
		CAL_ENABLE == CALIBRATION_STRAP) else $error("calibration enable wrong");
	clk_strap_a: assert property (DRIVE_ACTIVE |->
		REF_FROM_PIN == !CLOCK_SOURCE_STRAP) else $error("clock source wrong");
	rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside answer cycle");
	notify_pkt_a: assert property (PKT_VALID |-> ##[1:3] HOST_NOTIFY)
		else $error("no notify after packet");
	fault_stop_a: assert property (fault_s |-> ##[0:8] !DRIVE_ACTIVE && HOST_NOTIFY)
		else $error("fault did not stop drive");
	tx_timer_a: assert property (run_cnt_r <= TX_TIMER_CYCLES + 8)
		else $error("drive outlived transmitter timer");
endmodule : tmss_checker
bind tmss_top tmss_checker #(.TX_TIMER_CYCLES(TX_TIMER_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== dv/tmss_ref_model.sv ====
// reference clock source standing in for the board around the block
// assumes the bench sets the source strap before standby is released
`timescale 1ns/1ps
`default_nettype none
module tmss_ref_model #(
	parameter real HALF_NS = 62.5
) (
	input  wire logic clk_src_strap,
	output logic      ref_clk
);
	logic osc_r = 1'b0;
	// runs free, 8 MHz whatever the source
	always #(HALF_NS) osc_r = ~osc_r;
	// on-chip source: the pin is tied low, so stray counts would show
	assign ref_clk = clk_src_strap ? 1'b0 : osc_r;
endmodule : tmss_ref_model
`default_nettype wire

// ==== dv/tmss_tb.sv ====
// self-checking bench: boots the block under many strap sets
// assumes the rtl package, top, checker and reference model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "tmss_map.svh"
module testbench import tmss_pkg::*; ;
	localparam int unsigned TXT = 3000;
	logic        CORE_CLK = 1'b0;
	logic        RSTN = 1'b0;
	logic        STANDBY_RESET_IN = 1'b0;
	logic        REF_CLOCK_IN;
	logic [8:0]  straps = 9'h0; // cal,addr,clk,topo,pwc,pwb,pwa,auto,role
	logic        FAULT_IN = 1'b0;
	logic        PKT_VALID = 1'b0;
	logic [7:0]  PKT_POWER_ERR = 8'h00;
	logic [7:0]  REG_ADDR = 8'h00;
	logic [31:0] REG_WDATA = 32'h0;
	logic        REG_WR = 1'b0;
	logic        REG_RD = 1'b0;
	logic [31:0] REG_RDATA;
	logic        GATE1_HIGH, GATE1_LOW, GATE2_HIGH, GATE2_LOW, HOST_NOTIFY;
	logic        SERIAL_IS_CONTROLLER, CAL_ENABLE, REF_FROM_PIN, DRIVE_ACTIVE;
	logic [6:0]  SERIAL_TARGET_ADDR;
	int          miscompares = 0;
	int          tests_run = 0;
	int          seed = 32'ha420f6ae;
	logic [4:0]  base [7] = '{5'h00, 5'h03, 5'h02, 5'h1c, 5'h04, 5'h01, 5'h0e};
	always #5 CORE_CLK = ~CORE_CLK;
	tmss_ref_model u_ref (.clk_src_strap(straps[6]), .ref_clk(REF_CLOCK_IN));
	tmss_top #(.TX_TIMER_CYCLES(TXT)) DUT (.*, .BUS_ROLE_STRAP(straps[0]),
		.AUTO_POWER_STRAP(straps[1]), .PULSE_WIDTH_STRAP_A(straps[2]),
		.PULSE_WIDTH_STRAP_B(straps[3]), .PULSE_WIDTH_STRAP_C(straps[4]),
		.BRIDGE_TOPOLOGY_STRAP(straps[5]), .CLOCK_SOURCE_STRAP(straps[6]),
		.ADDRESS_STRAP(straps[7]), .CALIBRATION_STRAP(straps[8]));
	// -----------------------------------------------------------------
	// checks, bus cycles and expectations
	// -----------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmp_near(input int got, input int exp);
		tests_run++;
		if (got < exp - 2 || got > exp + 2) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_near
	task automatic cycles(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask : cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge CORE_CLK);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
	endtask : rd
	task automatic hold_cnt(input logic v, output int n);
		n = 0;
		while (GATE1_HIGH === v && n < 2000) begin
			@(negedge CORE_CLK);
			n++;
		end
	endtask : hold_cnt
	// one on-phase and one full period; a first pulse cut by the start is skipped
	task automatic measure(output int wid, output int per);
		int a;
		hold_cnt(1'b1, a);
		hold_cnt(1'b0, a);
		hold_cnt(1'b1, a);
		hold_cnt(1'b0, wid);
		hold_cnt(1'b1, a);
		per = wid + a;
	endtask : measure
	function automatic int ticks(input int t);
		return straps[6] ? t * 12 : t * 25 / 2;
	endfunction : ticks
	function automatic tmss_mode_t exp_mode(input logic [8:0] s);
		if (s[4:2] != 3'h0)
			return (s[1:0] == 2'b00) ? TMSS_M_STANDALONE : TMSS_M_INVALID;
		case (s[1:0])
			2'b11: return TMSS_M_APC_EEPROM;
			2'b10: return TMSS_M_APC_MCU;
			2'b00: return TMSS_M_MCU;
			default: return TMSS_M_INVALID;
		endcase
	endfunction : exp_mode
	function automatic logic [31:0] clamp_duty(input logic [9:0] d, input logic [7:0] e);
		int v;
		v = int'(d) + int'($signed(e));
		if (v < 0)
			v = 0;
		if (v > 'h80)
			v = 'h80;
		return 32'(v);
	endfunction : clamp_duty
	task automatic run_case(input logic [8:0] s);
		tmss_mode_t  m;
		int          w, p;
		logic [31:0] d0, d1;
		logic [7:0]  e8;
		m = exp_mode(s);
		@(posedge CORE_CLK);
		STANDBY_RESET_IN <= 1'b0;
		cycles(10);
		straps <= s;
		cycles(4);
		STANDBY_RESET_IN <= 1'b1;
		cycles(40);
		rd(`TMSS_A_STATUS, d0);
		cmp({20'h0, d0[15:4]}, {20'h0, s, m});
		cmp({22'h0, SERIAL_TARGET_ADDR, SERIAL_IS_CONTROLLER, CAL_ENABLE, REF_FROM_PIN},
			{22'h0, s[7] ? `TMSS_SADDR_HI : `TMSS_SADDR_LO, s[0], s[8], !s[6]});
		cmp({31'h0, DRIVE_ACTIVE}, {31'h0, m < TMSS_M_MCU});
		rd(8'h40, d0);
		cmp(d0, 32'h0);
		if (m == TMSS_M_STANDALONE) begin
			wr(`TMSS_A_FDRIVE, 32'h200);
			rd(`TMSS_A_FDRIVE, d0);
			cmp(d0, {21'h0, `TMSS_FDRV_DEF});
			measure(w, p);
			cmp_near(w, ticks(int'(s[4:2]) * 4));
			cmp_near(p, ticks(64));
			@(posedge CORE_CLK);
			FAULT_IN <= 1'b1;
			cycles(10);
			FAULT_IN <= 1'b0;
			rd(`TMSS_A_NOTIFY, d0);
			cmp(d0, 32'h2);
			cmp({31'h0, DRIVE_ACTIVE}, 32'h0);
		end else if (m == TMSS_M_APC_EEPROM || m == TMSS_M_APC_MCU) begin
			wr(`TMSS_A_DUTYMAX, 32'h80);
			rd(`TMSS_A_DUTYMAX, d0);
			cmp(d0, 32'h80);
			rd(`TMSS_A_DUTY, d0);
			e8 = 8'($random(seed));
			@(posedge CORE_CLK);
			PKT_VALID <= 1'b1;
			PKT_POWER_ERR <= e8;
			@(posedge CORE_CLK);
			PKT_VALID <= 1'b0;
			cycles(3);
			rd(`TMSS_A_DUTY, d1);
			cmp(d1, clamp_duty(d0[9:0], e8));
			rd(`TMSS_A_NOTIFY, d0);
			cmp(d0, 32'h1);
			wr(`TMSS_A_NOTIFY, 32'h1);
			cycles(2);
			cmp({31'h0, HOST_NOTIFY}, 32'h0);
		end else if (m == TMSS_M_MCU) begin
			@(posedge CORE_CLK);
			straps[2] <= 1'b1;
			cycles(6);
			rd(`TMSS_A_STATUS, d0);
			cmp({20'h0, d0[15:4]}, {20'h0, s, m});
			@(posedge CORE_CLK);
			straps[2] <= 1'b0;
			wr(`TMSS_A_DUTY, 32'h100);
			wr(`TMSS_A_CTRL, 32'h1);
			@(negedge CORE_CLK);
			cmp({31'h0, DRIVE_ACTIVE}, 32'h1);
			measure(w, p);
			cmp_near(w, ticks(16));
			cmp_near(p, ticks(64));
			wr(`TMSS_A_CTRL, 32'h2);
			@(negedge CORE_CLK);
			cmp({31'h0, DRIVE_ACTIVE}, 32'h0);
			wr(`TMSS_A_CTRL, 32'h1);
			cycles(TXT);
			cmp({31'h0, DRIVE_ACTIVE}, 32'h0);
			rd(`TMSS_A_NOTIFY, d0);
			cmp(d0, 32'h2);
			wr(`TMSS_A_CTRL, 32'h1);
			@(negedge CORE_CLK);
			cmp({31'h0, DRIVE_ACTIVE}, 32'h0);
		end
	endtask : run_case
	task automatic close_out;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	initial begin
		#1_000_000;
		miscompares++;
		close_out();
	end
	initial begin
		cycles(10);
		RSTN <= 1'b1;
		foreach (base[i])
			run_case({4'($random(seed)), base[i]});
		repeat (5)
			run_case(9'($random(seed)));
		close_out();
	end
endmodule : testbench
`default_nettype wire
